// ### include/eprom_prog_pkg.sv
// Purpose: shared constants for the eprom programming controller
// Assumes: 100 MHz clock, 64K x 16 part
// Notes:   times are in their printed units, cycles derived here
package eprom_prog_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned ADDR_W         = 16;
  localparam int unsigned DATA_W         = 16;
  // program pulse width, typical 100 us
  localparam int unsigned PULSE_US       = 100;
  localparam int unsigned PULSE_CYC      = PULSE_US * CLK_MHZ;
  // setup and hold, 1 us least, a whole number of cycles
  localparam int unsigned SETUP_US       = 1;
  localparam int unsigned SETUP_CYC      = SETUP_US * CLK_MHZ;
  // supply settle wait after switching rails
  localparam int unsigned SUPPLY_US      = 10;
  localparam int unsigned SUPPLY_CYC     = SUPPLY_US * CLK_MHZ;
  // read access: 150 ns longest plus margin, rounded up
  localparam int unsigned ACCESS_NS      = 200;
  localparam int unsigned ACCESS_CYC     = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MAX_PULSES     = 25;
  localparam int unsigned CNT_W          = 14;
  localparam int unsigned TRY_W          = 5;
  localparam logic [DATA_W-1:0] ERASED   = 16'hFFFF;
endpackage

// ### core/eprom_delay_timer.sv
// Purpose: loadable down counter that pulses when a wait ends
// Assumes: load and count share one clock
// Notes:   done is a one-cycle pulse on the last count
`timescale 1ns/100ps
`default_nettype none
module eprom_delay_timer (
  input  wire logic                                  clk_in,
  input  wire logic                                  rstn_in,
  input  wire logic                                  load_in,
  input  wire logic [eprom_prog_pkg::CNT_W-1:0]      count_in,
  output logic                                       done_out
);
  logic [eprom_prog_pkg::CNT_W-1:0] cnt_reg;
  logic [eprom_prog_pkg::CNT_W-1:0] cnt_next;
  logic                             done_reg;
  logic                             done_next;

  // count down, pulse at one so the caller sees exactly count cycles
  always_comb begin
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    if (load_in) begin
      cnt_next = count_in;
    end else if (cnt_reg != '0) begin
      cnt_next  = cnt_reg - 14'h0001;
      done_next = (cnt_reg == 14'h0001);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign done_out = done_reg;
endmodule
`default_nettype wire

// ### core/eprom_pin_sync.sv
// Purpose: two-flop synchroniser for the data bus read back from the part
// Assumes: data pins are asynchronous to clk_in
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module eprom_pin_sync (
  input  wire logic                               clk_in,
  input  wire logic                               rstn_in,
  input  wire logic [eprom_prog_pkg::DATA_W-1:0]  async_in,
  output logic      [eprom_prog_pkg::DATA_W-1:0]  sync_out
);
  logic [eprom_prog_pkg::DATA_W-1:0] meta_reg;
  logic [eprom_prog_pkg::DATA_W-1:0] sync_reg;

  // plain two-stage chain, per bit
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      meta_reg <= eprom_prog_pkg::ERASED;
      sync_reg <= eprom_prog_pkg::ERASED;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

// ### core/eprom_prog_ctrl.sv
// Purpose: host side controller that reads and programs a 64K x 16 eprom
// Assumes: rails switched by vpp_high_out / vcc_high_out level shifters
// Notes:   one request at a time; busy_out low means a request is taken
`timescale 1ns/100ps
`default_nettype none
module eprom_prog_ctrl (
  input  wire logic                               clk_in,
  input  wire logic                               rstn_in,
  input  wire logic                               rd_req_in,
  input  wire logic                               pg_req_in,
  input  wire logic [eprom_prog_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [eprom_prog_pkg::DATA_W-1:0]  wdata_in,
  output logic                                    busy_out,
  output logic                                    done_out,
  output logic                                    fail_out,
  output logic      [eprom_prog_pkg::DATA_W-1:0]  rdata_out,
  output logic      [eprom_prog_pkg::TRY_W-1:0]   tries_out,
  output logic      [eprom_prog_pkg::ADDR_W-1:0]  mem_addr_out,
  output logic                                    chip_sel_n_out,
  output logic                                    out_gate_n_out,
  output logic                                    program_strobe_n_out,
  input  wire logic [eprom_prog_pkg::DATA_W-1:0]  mem_data_in,
  output logic      [eprom_prog_pkg::DATA_W-1:0]  mem_data_out,
  output logic                                    mem_data_oe_out,
  output logic                                    vpp_high_out,
  output logic                                    vcc_high_out
);
  typedef enum logic [11:0] {
    S_IDLE    = 12'h001,
    S_RD_WAIT = 12'h002,
    S_RD_DONE = 12'h004,
    S_VCC_UP  = 12'h008,
    S_VPP_UP  = 12'h010,
    S_SETUP   = 12'h020,
    S_PULSE   = 12'h040,
    S_HOLD    = 12'h080,
    S_VERIFY  = 12'h100,
    S_VPP_DN  = 12'h200,
    S_VCC_DN  = 12'h400,
    S_FINISH  = 12'h800
  } state_e;

  // timer done lands a cycle before the sequencer acts on it, so load one less
  // to keep the strobe low for exactly the pulse length
  localparam logic [eprom_prog_pkg::CNT_W-1:0] PULSE_LD  = eprom_prog_pkg::CNT_W'(eprom_prog_pkg::PULSE_CYC - 1);
  localparam logic [eprom_prog_pkg::CNT_W-1:0] SETUP_LD  = eprom_prog_pkg::CNT_W'(eprom_prog_pkg::SETUP_CYC);
  localparam logic [eprom_prog_pkg::CNT_W-1:0] SUPPLY_LD = eprom_prog_pkg::CNT_W'(eprom_prog_pkg::SUPPLY_CYC);
  localparam logic [eprom_prog_pkg::CNT_W-1:0] ACCESS_LD = eprom_prog_pkg::CNT_W'(eprom_prog_pkg::ACCESS_CYC);
  localparam logic [eprom_prog_pkg::TRY_W-1:0] TRY_MAX   = eprom_prog_pkg::TRY_W'(eprom_prog_pkg::MAX_PULSES);

  state_e                             state_reg,   state_next;
  logic [eprom_prog_pkg::ADDR_W-1:0]  addr_reg,    addr_next;
  logic [eprom_prog_pkg::DATA_W-1:0]  wdata_reg,   wdata_next;
  logic [eprom_prog_pkg::DATA_W-1:0]  rdata_reg,   rdata_next;
  logic [eprom_prog_pkg::TRY_W-1:0]   tries_reg,   tries_next;
  logic                               done_reg,    done_next;
  logic                               fail_reg,    fail_next;
  logic                               cs_n_reg,    cs_n_next;
  logic                               oe_n_reg,    oe_n_next;
  logic                               pgm_n_reg,   pgm_n_next;
  logic                               doe_reg,     doe_next;
  logic                               vpp_reg,     vpp_next;
  logic                               vcc_reg,     vcc_next;
  logic                               busy_reg,    busy_next;
  logic                               ld;
  logic [eprom_prog_pkg::CNT_W-1:0]   ld_val;
  logic                               tmr_done;
  logic [eprom_prog_pkg::DATA_W-1:0]  rd_sync;

  // verify passes when every zero asked for reads zero; ones cannot be forced
  function automatic logic word_ok(input logic [15:0] want, input logic [15:0] got);
    word_ok = ((~want & got) == 16'h0000);
  endfunction

  eprom_delay_timer u_timer (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .load_in  (ld),
    .count_in (ld_val),
    .done_out (tmr_done)
  );

  eprom_pin_sync u_sync (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .async_in (mem_data_in),
    .sync_out (rd_sync)
  );

  // sequencer: one state per pin phase so every edge has its own setup
  always_comb begin
    state_next = state_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    tries_next = tries_reg;
    done_next  = 1'b0;
    fail_next  = fail_reg;
    cs_n_next  = cs_n_reg;
    oe_n_next  = oe_n_reg;
    pgm_n_next = 1'b1;                  // strobe idles high
    doe_next   = doe_reg;
    vpp_next   = vpp_reg;
    vcc_next   = vcc_reg;
    ld         = 1'b0;
    ld_val     = ACCESS_LD;
    case (state_reg)
      S_IDLE: begin
        cs_n_next = 1'b1;               // standby between requests
        oe_n_next = 1'b1;
        doe_next  = 1'b0;
        if (rd_req_in) begin
          addr_next  = addr_in;
          cs_n_next  = 1'b0;
          oe_n_next  = 1'b0;            // read needs both selects low
          ld         = 1'b1;
          ld_val     = ACCESS_LD;
          state_next = S_RD_WAIT;
        end else if (pg_req_in) begin
          addr_next  = addr_in;
          wdata_next = wdata_in;
          tries_next = '0;
          fail_next  = 1'b0;
          vcc_next   = 1'b1;            // vcc rises first
          ld         = 1'b1;
          ld_val     = SUPPLY_LD;
          state_next = S_VCC_UP;
        end
      end
      S_RD_WAIT: begin
        if (tmr_done) begin
          state_next = S_RD_DONE;
        end
      end
      S_RD_DONE: begin
        rdata_next = rd_sync;           // two flops after the access wait
        fail_next  = 1'b0;
        done_next  = 1'b1;
        cs_n_next  = 1'b1;
        oe_n_next  = 1'b1;
        state_next = S_IDLE;
      end
      S_VCC_UP: begin
        if (tmr_done) begin
          vpp_next   = 1'b1;            // strobe already high here
          ld         = 1'b1;
          ld_val     = SUPPLY_LD;
          state_next = S_VPP_UP;
        end
      end
      S_VPP_UP: begin
        if (tmr_done) begin
          oe_n_next  = 1'b1;            // gate high selects programming
          cs_n_next  = 1'b0;            // chip select low enables write
          doe_next   = 1'b1;            // full word onto the pins
          ld         = 1'b1;
          ld_val     = SETUP_LD;
          state_next = S_SETUP;
        end
      end
      S_SETUP: begin
        if (tmr_done) begin
          pgm_n_next = 1'b0;            // one timed pulse per try
          tries_next = tries_reg + 5'h01;
          ld         = 1'b1;
          ld_val     = PULSE_LD;
          state_next = S_PULSE;
        end
      end
      S_PULSE: begin
        pgm_n_next = 1'b0;
        if (tmr_done) begin
          pgm_n_next = 1'b1;            // pulse ends after 100 us
          ld         = 1'b1;
          ld_val     = SETUP_LD;
          state_next = S_HOLD;
        end
      end
      S_HOLD: begin
        if (tmr_done) begin
          doe_next   = 1'b0;            // release bus on the same edge the gate goes low
          oe_n_next  = 1'b0;            // verify with vpp still high
          ld         = 1'b1;
          ld_val     = SETUP_LD;
          state_next = S_VERIFY;
        end
      end
      S_VERIFY: begin
        if (tmr_done) begin
          rdata_next = rd_sync;
          oe_n_next  = 1'b1;
          if (word_ok(wdata_reg, rd_sync)) begin
            vpp_next   = 1'b0;
            cs_n_next  = 1'b1;
            ld         = 1'b1;
            ld_val     = SUPPLY_LD;
            state_next = S_VPP_DN;
          end else if (tries_reg >= TRY_MAX) begin
            fail_next  = 1'b1;          // give up after 25 pulses
            vpp_next   = 1'b0;
            cs_n_next  = 1'b1;
            ld         = 1'b1;
            ld_val     = SUPPLY_LD;
            state_next = S_VPP_DN;
          end else begin
            doe_next   = 1'b1;
            ld         = 1'b1;
            ld_val     = SETUP_LD;
            state_next = S_SETUP;
          end
        end
      end
      S_VPP_DN: begin
        if (tmr_done) begin
          vcc_next   = 1'b0;            // vcc drops last
          ld         = 1'b1;
          ld_val     = SUPPLY_LD;
          state_next = S_VCC_DN;
        end
      end
      S_VCC_DN: begin
        if (tmr_done) begin
          state_next = S_FINISH;
        end
      end
      S_FINISH: begin
        done_next  = 1'b1;
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    busy_next = (state_next != S_IDLE); // registered so the output is glitch free
  end

  // register everything; pins power up deselected with rails at 5 V
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_reg <= S_IDLE;
      addr_reg  <= 16'h0000;
      wdata_reg <= 16'hFFFF;
      rdata_reg <= 16'h0000;
      tries_reg <= 5'h00;
      done_reg  <= 1'b0;
      fail_reg  <= 1'b0;
      cs_n_reg  <= 1'b1;
      oe_n_reg  <= 1'b1;
      pgm_n_reg <= 1'b1;
      doe_reg   <= 1'b0;
      vpp_reg   <= 1'b0;
      vcc_reg   <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      tries_reg <= tries_next;
      done_reg  <= done_next;
      fail_reg  <= fail_next;
      cs_n_reg  <= cs_n_next;
      oe_n_reg  <= oe_n_next;
      pgm_n_reg <= pgm_n_next;
      doe_reg   <= doe_next;
      vpp_reg   <= vpp_next;
      vcc_reg   <= vcc_next;
      busy_reg  <= busy_next;
    end
  end

  assign busy_out             = busy_reg;
  assign done_out             = done_reg;
  assign fail_out             = fail_reg;
  assign rdata_out            = rdata_reg;
  assign tries_out            = tries_reg;
  assign mem_addr_out         = addr_reg;
  assign chip_sel_n_out       = cs_n_reg;
  assign out_gate_n_out       = oe_n_reg;
  assign program_strobe_n_out = pgm_n_reg;
  assign mem_data_out         = wdata_reg;
  assign mem_data_oe_out      = doe_reg;
  assign vpp_high_out         = vpp_reg;
  assign vcc_high_out         = vcc_reg;
endmodule
`default_nettype wire

// ### dv/eprom_prog_ctrl_chk.sv
// Purpose: port level checks on the eprom programming controller
// Assumes: one clock domain, sees only the controller ports
// Notes:   pulse width is counted in helper logic, too long to repeat
`timescale 1ns/100ps
`default_nettype none
module eprom_prog_ctrl_chk (
  input  wire logic                              clk_in,
  input  wire logic                              rstn_in,
  input  wire logic                              rd_req_in,
  input  wire logic                              busy_out,
  input  wire logic                              done_out,
  input  wire logic [eprom_prog_pkg::TRY_W-1:0]  tries_out,
  input  wire logic                              chip_sel_n_out,
  input  wire logic                              out_gate_n_out,
  input  wire logic                              program_strobe_n_out,
  input  wire logic                              mem_data_oe_out,
  input  wire logic                              vpp_high_out,
  input  wire logic                              vcc_high_out
);
  logic [eprom_prog_pkg::CNT_W-1:0] low_cnt_reg;
  logic [eprom_prog_pkg::CNT_W-1:0] low_cnt_next;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // strobe low cycles, cleared while high so each pulse stands alone
  always_comb begin
    low_cnt_next = program_strobe_n_out ? '0 : low_cnt_reg + 1'b1;
  end
  always_ff @(posedge clk_in) begin
    low_cnt_reg <= rstn_in ? low_cnt_next : '0;
  end
  a_strobe_mode: assert property (!program_strobe_n_out |-> !chip_sel_n_out && out_gate_n_out
    && vpp_high_out && mem_data_oe_out) else $error("strobe low outside programming mode");
  a_pulse_width: assert property ($rose(program_strobe_n_out) |-> low_cnt_reg == eprom_prog_pkg::PULSE_CYC)
    else $error("program pulse width wrong");
  a_vcc_first: assert property ($rose(vpp_high_out) |-> $past(vcc_high_out, 8) && program_strobe_n_out)
    else $error("vpp raised without vcc or strobe high");
  a_vpp_under_vcc: assert property (vpp_high_out |-> vcc_high_out)
    else $error("vpp high while vcc low");
  a_vcc_last: assert property ($fell(vcc_high_out) |-> !vpp_high_out && $past(vpp_high_out, 8) == 1'b0)
    else $error("vcc dropped before vpp");
  a_idle_rails: assert property (!busy_out |-> !vpp_high_out && !vcc_high_out && program_strobe_n_out)
    else $error("rails raised while idle");
  a_no_contention: assert property (mem_data_oe_out |-> out_gate_n_out)
    else $error("data driven while gate low");
  a_tries_bound: assert property (tries_out <= eprom_prog_pkg::MAX_PULSES)
    else $error("too many pulses");
  a_read_timing: assert property ((!busy_out && rd_req_in) |=> (!chip_sel_n_out && !out_gate_n_out)[*8]
    ##15 done_out) else $error("read cycle timing wrong");
  c_pulse: cover property ($rose(program_strobe_n_out));
  c_retry: cover property (done_out && tries_out == 5'h02);
  c_read: cover property (!busy_out && rd_req_in);
endmodule
bind eprom_prog_ctrl eprom_prog_ctrl_chk i_eprom_prog_ctrl_chk (.clk_in, .rstn_in, .rd_req_in, .busy_out,
  .done_out, .tries_out, .chip_sel_n_out, .out_gate_n_out, .program_strobe_n_out, .mem_data_oe_out,
  .vpp_high_out, .vcc_high_out);
`default_nettype wire

// ### dv/eprom_model.sv
// Purpose: behavioural model of the 64K x 16 memory part
// Assumes: rails given as levels, pins as logic
// Notes:   slow cells need two pulses; released pins show inverted junk
`timescale 1ns/100ps
`default_nettype none
module eprom_model (
  input  wire logic        chip_sel_n_in,
  input  wire logic        out_gate_n_in,
  input  wire logic        program_strobe_n_in,
  input  wire logic        vpp_high_in,
  input  wire logic        vcc_high_in,
  input  wire logic        slow_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] data_in,
  output logic      [15:0] q_out
);
  logic [15:0] mem [0:65535];
  logic [15:0] last;
  logic        drive;
  int          pulses;
  // erased array reads all ones
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 16'hFFFF;
    last = 16'h0000;
    pulses = 0;
  end
  // outputs only with both selects low, else floating (inverse of last word)
  assign drive = !chip_sel_n_in && !out_gate_n_in;
  always @(drive or addr_in) if (drive) last = mem[addr_in];
  assign q_out = drive ? mem[addr_in] : ~last;
  // word taken at end of a legal pulse; only clears bits
  always @(posedge program_strobe_n_in) begin
    if (!chip_sel_n_in && out_gate_n_in && vpp_high_in && vcc_high_in) begin
      pulses++;
      if (pulses >= (slow_in ? 2 : 1)) mem[addr_in] = mem[addr_in] & data_in;
    end
  end
  always @(negedge chip_sel_n_in) pulses = 0;
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Purpose: self checking bench for the eprom programming controller
// Assumes: inputs change at the falling edge
// Notes:   the 25 pulse give-up is left to the checker, it would run too long
`timescale 1ns/100ps
`default_nettype none
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin n_mismatch++; \
  $display("ERROR t=%0t got %h expected %h", $time, (act), (exp)); end end
module tb_top;
  typedef struct packed {logic pg; logic [15:0] data; logic [4:0] tries;} exp_s;
  logic        clk_in, rstn_in, rd_req_in, pg_req_in, busy_out, done_out, fail_out, slow;
  logic        chip_sel_n_out, out_gate_n_out, program_strobe_n_out, mem_data_oe_out;
  logic        vpp_high_out, vcc_high_out;
  logic [15:0] addr_in, wdata_in, rdata_out, mem_addr_out, mem_data_in, mem_data_out, q, a, w, w2;
  logic [4:0]  tries_out;
  int          n_mismatch, checked, seed;
  exp_s        exp_q[$];
  exp_s        e;
  eprom_prog_ctrl i_eprom_prog_ctrl (.clk_in, .rstn_in, .rd_req_in, .pg_req_in, .addr_in, .wdata_in,
    .busy_out, .done_out, .fail_out, .rdata_out, .tries_out, .mem_addr_out, .chip_sel_n_out,
    .out_gate_n_out, .program_strobe_n_out, .mem_data_in, .mem_data_out, .mem_data_oe_out,
    .vpp_high_out, .vcc_high_out);
  eprom_model i_eprom_model (.chip_sel_n_in(chip_sel_n_out), .out_gate_n_in(out_gate_n_out),
    .program_strobe_n_in(program_strobe_n_out), .vpp_high_in(vpp_high_out), .vcc_high_in(vcc_high_out),
    .slow_in(slow), .addr_in(mem_addr_out), .data_in(mem_data_in), .q_out(q));
  // data pins: the controller wins while it drives, else the part
  assign mem_data_in = mem_data_oe_out ? mem_data_out : q;
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic end_of_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one request, optional read poke while busy, then wait for done
  task automatic run(input logic rd, input logic pg, input logic [15:0] ad, input logic [15:0] d,
                     input exp_s ex, input logic poke);
    int n;
    exp_q.push_back(ex);
    rd_req_in = rd;
    pg_req_in = pg;
    addr_in = ad;
    wdata_in = d;
    @(negedge clk_in);
    rd_req_in = 1'b0;
    pg_req_in = 1'b0;
    addr_in = 16'($random(seed));
    wdata_in = 16'($random(seed));
    if (poke) begin
      repeat (50) @(negedge clk_in);
      rd_req_in = 1'b1;
      @(negedge clk_in);
      rd_req_in = 1'b0;
    end
    n = 0;
    while (done_out !== 1'b1 && n < 40000) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 40000) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  // results settle by the falling edge; each done takes the oldest note
  always @(negedge clk_in) begin
    if (done_out === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK(done_out, 1'b0)
      end else begin
        e = exp_q.pop_front();
        `CHK(rdata_out, e.data)
        if (e.pg) begin
          `CHK(tries_out, e.tries)
          `CHK(fail_out, 1'b0)
        end
      end
    end
  end
  initial begin
    repeat (80000) @(posedge clk_in);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    seed = 32'hF2688E9D;
    n_mismatch = 0;
    checked = 0;
    {rstn_in, rd_req_in, pg_req_in, slow} = 4'h0;
    addr_in = 16'h0000;
    wdata_in = 16'h0000;
    repeat (20) @(negedge clk_in);
    `CHK({program_strobe_n_out, chip_sel_n_out, vpp_high_out, vcc_high_out}, 4'hC)
    rstn_in = 1'b1;
    // erased words read as ones, requests back to back
    for (int i = 0; i < 4; i++) run(1'b1, 1'b0, 16'($random(seed)), 16'h0000, exp_s'{1'b0, 16'hFFFF, 5'h00}, 1'b0);
    $display("test erased_read done");
    a = 16'($random(seed));
    w = 16'($random(seed));
    w2 = 16'($random(seed));
    // one pulse programs, a read poked in while busy is ignored
    run(1'b0, 1'b1, a, w, exp_s'{1'b1, w, 5'h01}, 1'b1);
    run(1'b1, 1'b0, a, 16'h0000, exp_s'{1'b0, w, 5'h00}, 1'b0);
    $display("test program_once done");
    // a second word can only clear more bits
    run(1'b0, 1'b1, a, w2, exp_s'{1'b1, w & w2, 5'h01}, 1'b0);
    run(1'b1, 1'b0, a, 16'h0000, exp_s'{1'b0, w & w2, 5'h00}, 1'b0);
    $display("test overprogram done");
    // slow cells fail the first verify and need a second pulse
    slow = 1'b1;
    w = 16'($random(seed)) & 16'h7FFE;
    run(1'b0, 1'b1, a + 16'h0001, w, exp_s'{1'b1, w, 5'h02}, 1'b0);
    run(1'b1, 1'b0, a + 16'h0001, 16'h0000, exp_s'{1'b0, w, 5'h00}, 1'b0);
    $display("test retry done");
    repeat (4) @(negedge clk_in);
    `CHK(exp_q.size(), 0)
    end_of_test();
  end
endmodule
`default_nettype wire
